// [auth_pkg.sv]
package auth_pkg;

  localparam int SEED_W = 128;
  localparam int HALF_W = 64;
  localparam int CHAL_W = 128;
  localparam int KEY_W = 128;
  localparam int RESP_W = 32;
  localparam int CIPHER_W = 128;

  // Outcome codes shown on the result port.
  localparam logic [1:0] OUTCOME_NONE = 2'h0;
  localparam logic [1:0] OUTCOME_PASS = 2'h1;
  localparam logic [1:0] OUTCOME_FAIL = 2'h2;

  // Longest wait for a reply from the portable side, in ns and cycles.
  localparam longint REPLY_TIMEOUT_NS = 64'd1000000;
  localparam longint CLK_PERIOD_NS = 64'd20;
  localparam int REPLY_TIMEOUT_CYC = int'(REPLY_TIMEOUT_NS / CLK_PERIOD_NS);

  typedef struct packed {
    logic [HALF_W-1:0] seed_high_half;
    logic [HALF_W-1:0] seed_low_half;
  } session_seed_t;

  // Request sent to the portable terminal.
  typedef struct packed {
    logic [CHAL_W-1:0] fixed_challenge;
    session_seed_t session_seed;
  } auth_request_t;

  // Reply returned by the portable terminal.
  typedef struct packed {
    logic [RESP_W-1:0] portable_response;
    logic [CHAL_W-1:0] portable_challenge;
  } auth_reply_t;

  // Output of the response derivation engine.
  typedef struct packed {
    logic [RESP_W-1:0] expected_response;
    logic [CIPHER_W-1:0] derived_cipher_key;
  } derive_result_t;

endpackage

// [seed_key_cache.sv]
`timescale 1ns/100ps

// ****************************************
// Cached seed and session key pair
// ****************************************
module seed_key_cache #(
  parameter int SEED_BITS = 128,
  parameter int KEY_BITS = 128
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Write side
  input wire logic write_en,
  input wire logic [SEED_BITS-1:0] write_seed,
  input wire logic [KEY_BITS-1:0] write_key,
  input wire logic pinned_in,
  // Read side
  output logic valid,
  output logic pinned,
  output logic [SEED_BITS-1:0] seed,
  output logic [KEY_BITS-1:0] key
);

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      valid <= 1'b0;
      pinned <= 1'b0;
      seed <= '0;
      key <= '0;
    end else if (write_en) begin
      valid <= 1'b1;
      pinned <= pinned_in;
      seed <= write_seed;
      key <= write_key;
    end
  end

endmodule

// [fixed_auth_controller.sv]
`timescale 1ns/100ps
// Functional notes
// - Seed is 128 bits; high 64-bit half sits in the upper bits.
// - Every random value, seed included, is consumed once only.
// - Seed halves travel as one combined 128-bit seed on the link.
// - Each fresh derivation starts from a never-used 128-bit seed.
// - Session key is derived from the fresh seed and subscriber secret.
// - Last derived key and its seed are kept; reuse allowed.
// - A seed enters session key derivation only once.
// - A new seed is fetched only when a run needs a new key; the stored key never lags its seed.
// - A fresh fixed challenge is drawn for every run.
// - Request carries the fixed challenge and the 128-bit seed.
// - Expected response is computed; accept only on exact match.
// - Cipher key from the own response derivation is captured.
// - A visited system sends its given seed with its challenge.

// ****************************************
// Fixed terminal authentication controller
// ****************************************
module fixed_auth_controller #(
  parameter int TIMEOUT_CYCLES = auth_pkg::REPLY_TIMEOUT_CYC
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // User side
  input wire logic start,
  input wire logic force_new_key,
  input wire logic load_visited,
  input wire auth_pkg::session_seed_t visited_seed,
  input wire logic [auth_pkg::KEY_W-1:0] visited_key,
  output logic busy,
  output logic done,
  output logic [1:0] outcome,
  output logic authenticated,
  output logic [auth_pkg::CIPHER_W-1:0] derived_cipher_key,
  // Random source
  output logic rand_req,
  input wire logic rand_ack,
  input wire logic [auth_pkg::CHAL_W-1:0] rand_data,
  // Session key derivation engine
  output logic skd_start,
  output auth_pkg::session_seed_t skd_seed,
  input wire logic skd_done,
  input wire logic [auth_pkg::KEY_W-1:0] skd_key,
  // Response derivation engine
  output logic rd_start,
  output logic [auth_pkg::KEY_W-1:0] rd_key,
  output logic [auth_pkg::CHAL_W-1:0] rd_fixed_challenge,
  output logic [auth_pkg::CHAL_W-1:0] rd_portable_challenge,
  input wire logic rd_done,
  input wire auth_pkg::derive_result_t rd_result,
  // Link to portable terminal
  output logic req_valid,
  input wire logic req_ready,
  output auth_pkg::auth_request_t req_msg,
  input wire logic reply_valid,
  input wire auth_pkg::auth_reply_t reply_msg
);
  import auth_pkg::*;

  // A zero wait would wrap the limit to the largest count, so the timeout would fire only after about 2^32 cycles.
  if (TIMEOUT_CYCLES < 1) begin : g_bad_timeout
    $error("TIMEOUT_CYCLES must be at least 1");
  end

  typedef enum logic [3:0] {
    IDLE, GET_SEED, DERIVE_KEY, GET_CHAL, SEND_REQ, WAIT_REPLY, DERIVE_RESP, FINISH
  } state_t;

  state_t state;
  logic [CHAL_W-1:0] fixed_challenge;
  logic [CHAL_W-1:0] portable_challenge;
  logic [RESP_W-1:0] portable_response;
  session_seed_t fresh_seed;
  logic fresh_valid;
  logic [31:0] wait_count;
  logic cache_valid;
  logic cache_pinned;
  logic [SEED_W-1:0] cache_seed;
  logic [KEY_W-1:0] cache_key;
  logic cache_we;
  logic visited_load;
  logic [SEED_W-1:0] cache_wseed;
  logic [KEY_W-1:0] cache_wkey;
  logic need_key;

  // ****************************************
  // Seed and key cache
  // ****************************************
  // keep last pair
  seed_key_cache #(.SEED_BITS(SEED_W), .KEY_BITS(KEY_W)) u_cache (
    .ref_clk(ref_clk),
    .reset(reset),
    .write_en(cache_we),
    .write_seed(cache_wseed),
    .write_key(cache_wkey),
    .pinned_in(visited_load),
    .valid(cache_valid),
    .pinned(cache_pinned),
    .seed(cache_seed),
    .key(cache_key)
  );

  // A visited pair loads only when idle; a derived pair is written on completion.
  // The pin flag follows the idle load alone, so a late load request cannot pin a derived pair.
  assign visited_load = (state == IDLE) && load_visited;
  assign cache_we = visited_load || (state == DERIVE_KEY && skd_done);
  assign cache_wseed = visited_load ? visited_seed : fresh_seed;
  assign cache_wkey = visited_load ? visited_key : skd_key;

  assign need_key = !cache_pinned && (force_new_key || !cache_valid);

  // ****************************************
  // Sequencer
  // ****************************************
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      state <= IDLE;
    end else begin
      unique case (state)
        IDLE: begin
          if (start && !load_visited) begin
            state <= need_key ? (fresh_valid ? DERIVE_KEY : GET_SEED) : GET_CHAL;
          end
        end
        GET_SEED: begin
          if (rand_ack) begin
            state <= DERIVE_KEY;
          end
        end
        DERIVE_KEY: begin
          if (skd_done) begin
            state <= GET_CHAL;
          end
        end
        GET_CHAL: begin
          if (rand_ack) begin
            state <= SEND_REQ;
          end
        end
        SEND_REQ: begin
          if (req_ready) begin
            state <= WAIT_REPLY;
          end
        end
        WAIT_REPLY: begin
          if (reply_valid) begin
            state <= DERIVE_RESP;
          end else if (wait_count >= 32'(TIMEOUT_CYCLES - 1)) begin
            state <= FINISH;
          end
        end
        DERIVE_RESP: begin
          if (rd_done) begin
            state <= FINISH;
          end
        end
        FINISH: begin
          state <= IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      wait_count <= '0;
    end else if (state == WAIT_REPLY) begin
      wait_count <= wait_count + 32'h1;
    end else begin
      wait_count <= '0;
    end
  end

  // ****************************************
  // Random values
  // ****************************************
  // fresh seed drawn
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      fresh_seed <= '0;
      fresh_valid <= 1'b0;
    end else if (state == GET_SEED && rand_ack) begin
      fresh_seed <= rand_data;
      fresh_valid <= 1'b1;
    end else if (state == DERIVE_KEY && skd_done) begin
      fresh_valid <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      fixed_challenge <= '0;
    end else if (state == GET_CHAL && rand_ack) begin
      fixed_challenge <= rand_data;
    end
  end

  assign rand_req = (state == GET_SEED) || (state == GET_CHAL);

  assign skd_start = (state == DERIVE_KEY);
  assign skd_seed = fresh_seed;

  // ****************************************
  // Link messages
  // ****************************************
  // request contents
  assign req_valid = (state == SEND_REQ);
  assign req_msg = '{fixed_challenge: fixed_challenge, session_seed: cache_seed};

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      portable_challenge <= '0;
      portable_response <= '0;
    end else if (state == WAIT_REPLY && reply_valid) begin
      portable_challenge <= reply_msg.portable_challenge;
      portable_response <= reply_msg.portable_response;
    end
  end

  assign rd_start = (state == DERIVE_RESP);
  assign rd_key = cache_key;
  assign rd_fixed_challenge = fixed_challenge;
  assign rd_portable_challenge = portable_challenge;

  // ****************************************
  // Outcome
  // ****************************************
  // compare responses
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      outcome <= OUTCOME_NONE;
      authenticated <= 1'b0;
    end else if (state == DERIVE_RESP && rd_done) begin
      authenticated <= (rd_result.expected_response == portable_response);
      outcome <= (rd_result.expected_response == portable_response) ? OUTCOME_PASS : OUTCOME_FAIL;
    end else if (state == WAIT_REPLY && !reply_valid && wait_count >= 32'(TIMEOUT_CYCLES - 1)) begin
      authenticated <= 1'b0;
      outcome <= OUTCOME_FAIL;
    end else if (state == IDLE && start && !load_visited) begin
      authenticated <= 1'b0;
      outcome <= OUTCOME_NONE;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      derived_cipher_key <= '0;
    end else if (state == DERIVE_RESP && rd_done) begin
      derived_cipher_key <= rd_result.derived_cipher_key;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      done <= 1'b0;
    end else begin
      done <= (state == FINISH);
    end
  end

  assign busy = (state != IDLE);

  // ****************************************
  // Checks
  // ****************************************
  sequence s_match;
    state == DERIVE_RESP && rd_done && rd_result.expected_response == portable_response;
  endsequence

  sequence s_mismatch;
    state == DERIVE_RESP && rd_done && rd_result.expected_response != portable_response;
  endsequence

  property p_accept;
    @(posedge ref_clk) disable iff (reset) s_match |=> authenticated && outcome == OUTCOME_PASS ##1 done;
  endproperty
  a_accept: assert property (p_accept) else $error("match not accepted");

  property p_reject;
    @(posedge ref_clk) disable iff (reset) s_mismatch |=> !authenticated && outcome == OUTCOME_FAIL;
  endproperty
  a_reject: assert property (p_reject) else $error("mismatch accepted");

  property p_req_seed;
    @(posedge ref_clk) disable iff (reset) req_valid |-> req_msg.session_seed == cache_seed && cache_valid;
  endproperty
  a_req_seed: assert property (p_req_seed) else $error("request seed wrong");

  property p_req_hold;
    @(posedge ref_clk) disable iff (reset) (req_valid && !req_ready) |=> req_valid && $stable(req_msg);
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("request dropped before accept");

  property p_seed_once;
    @(posedge ref_clk) disable iff (reset) (state == DERIVE_KEY && skd_done) |=> !fresh_valid;
  endproperty
  a_seed_once: assert property (p_seed_once) else $error("seed reused");

  property p_cache_write;
    @(posedge ref_clk) disable iff (reset)
      (state == DERIVE_KEY && skd_done) |=> cache_seed == $past(fresh_seed) && cache_key == $past(skd_key);
  endproperty
  a_cache_write: assert property (p_cache_write) else $error("key not cached");

  property p_chal_fresh;
    @(posedge ref_clk) disable iff (reset)
      (state == GET_CHAL && rand_ack) |=> fixed_challenge == $past(rand_data) ##1 1'b1;
  endproperty
  a_chal_fresh: assert property (p_chal_fresh) else $error("challenge not taken");

  property p_dck;
    @(posedge ref_clk) disable iff (reset)
      (state == DERIVE_RESP && rd_done) |=> derived_cipher_key == $past(rd_result.derived_cipher_key);
  endproperty
  a_dck: assert property (p_dck) else $error("cipher key not captured");

  property p_pinned;
    @(posedge ref_clk) disable iff (reset) (cache_pinned && state == IDLE && start && !load_visited) |=> state == GET_CHAL;
  endproperty
  a_pinned: assert property (p_pinned) else $error("visited pair not reused");

  property p_skd_seed;
    @(posedge ref_clk) disable iff (reset) skd_start |-> fresh_valid && skd_seed == fresh_seed;
  endproperty
  a_skd_seed: assert property (p_skd_seed) else $error("derivation without fresh seed");

endmodule

// [portable_terminal_model.sv]
`timescale 1ns/100ps

// ****************************************
// Portable terminal model
// ****************************************
module portable_terminal_model #(
  parameter logic [127:0] SECRET = 128'h5a5a_1234_0f0f_9876_c3c3_4444_a5a5_0101
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Scenario controls
  input wire logic corrupt,
  input wire logic mute,
  input wire logic [3:0] delay,
  output int derive_count,
  // Link
  input wire logic req_valid,
  output logic req_ready,
  input wire auth_pkg::auth_request_t req_msg,
  output logic reply_valid,
  output auth_pkg::auth_reply_t reply_msg
);
  import auth_pkg::*;
  logic pend;
  logic cached;
  logic [3:0] wait_cnt;
  logic [CHAL_W-1:0] fc;
  logic [CHAL_W-1:0] pc;
  logic [SEED_W-1:0] cached_seed;
  logic [KEY_W-1:0] cached_key;
  logic [KEY_W-1:0] mix;

  assign mix = cached_key ^ fc ^ pc;

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      req_ready <= 1'b0;
      cached <= 1'b0;
      derive_count <= 0;
      pc <= 128'h1000;
    end else begin
      req_ready <= req_valid && !req_ready && !pend;
      if (req_valid && req_ready) begin
        fc <= req_msg.fixed_challenge;
        pc <= pc + 128'h1;
        if (!cached || cached_seed !== req_msg.session_seed) begin
          cached <= 1'b1;
          cached_seed <= req_msg.session_seed;
          cached_key <= req_msg.session_seed ^ SECRET;
          derive_count <= derive_count + 1;
        end
      end
    end
  end

  // The idle reply bus toggles so that a stale value is never mistaken for a reply.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      pend <= 1'b0;
      reply_valid <= 1'b0;
      reply_msg <= '0;
    end else if (req_valid && req_ready) begin
      pend <= !mute;
      wait_cnt <= delay;
    end else if (pend && wait_cnt == 4'h0) begin
      pend <= 1'b0;
      reply_valid <= 1'b1;
      reply_msg.portable_response <= mix[RESP_W-1:0] ^ {31'h0, corrupt};
      reply_msg.portable_challenge <= pc;
    end else begin
      wait_cnt <= wait_cnt - 4'h1;
      reply_valid <= 1'b0;
      reply_msg <= ~reply_msg;
    end
  end
endmodule

// [portable_auth_type2_sequencer_tb_top.sv]
`timescale 1ns/100ps

// ****************************************
// Testbench
// ****************************************
module portable_auth_type2_sequencer_tb_top;
  import auth_pkg::*;
  localparam logic [127:0] SECRET = 128'h5a5a_1234_0f0f_9876_c3c3_4444_a5a5_0101;
  logic ref_clk = 0, reset = 1, start = 0, force_new_key = 0, load_visited = 0;
  session_seed_t visited_seed = '0;
  logic [KEY_W-1:0] visited_key = '0;
  logic busy, done, authenticated, rand_req, skd_start, rd_start, req_valid, reply_valid;
  logic [1:0] outcome;
  logic [CIPHER_W-1:0] derived_cipher_key;
  logic rand_ack = 0, skd_done = 0, rd_done = 0, corrupt = 0, mute = 0;
  logic [3:0] delay = 0;
  logic [127:0] rand_data = 0, skd_key = 0, prev_seed = 0, last_seed;
  session_seed_t skd_seed;
  logic [KEY_W-1:0] rd_key, mix;
  logic [CHAL_W-1:0] rd_fixed_challenge, rd_portable_challenge;
  derive_result_t rd_result = '0;
  logic req_ready;
  auth_request_t req_msg, seen_req;
  auth_reply_t reply_msg, seen_reply;
  int derive_count, num_errors = 0, checked = 0, rand_count = 0, skd_runs = 0, rd_runs = 0;

  fixed_auth_controller #(.TIMEOUT_CYCLES(20)) u_dut (.ref_clk(ref_clk), .reset(reset), .start(start),
    .force_new_key(force_new_key), .load_visited(load_visited), .visited_seed(visited_seed),
    .visited_key(visited_key), .busy(busy), .done(done), .outcome(outcome), .authenticated(authenticated),
    .derived_cipher_key(derived_cipher_key), .rand_req(rand_req), .rand_ack(rand_ack), .rand_data(rand_data),
    .skd_start(skd_start), .skd_seed(skd_seed), .skd_done(skd_done), .skd_key(skd_key), .rd_start(rd_start),
    .rd_key(rd_key), .rd_fixed_challenge(rd_fixed_challenge), .rd_portable_challenge(rd_portable_challenge),
    .rd_done(rd_done), .rd_result(rd_result), .req_valid(req_valid), .req_ready(req_ready),
    .req_msg(req_msg), .reply_valid(reply_valid), .reply_msg(reply_msg));

  portable_terminal_model #(.SECRET(SECRET)) u_pt (.ref_clk(ref_clk), .reset(reset), .corrupt(corrupt),
    .mute(mute), .delay(delay), .derive_count(derive_count), .req_valid(req_valid), .req_ready(req_ready),
    .req_msg(req_msg), .reply_valid(reply_valid), .reply_msg(reply_msg));

  initial begin
    forever #10 ref_clk = ~ref_clk;
  end

  // Distinct halves make a swapped seed visible at once.
  function automatic logic [127:0] rnd(input int n);
    return {64'h0123_4567_89ab_cdef + 64'(n), 64'hfedc_ba98_7654_3210 - 64'(n)};
  endfunction

  // ****************************************
  // Engines and link monitor
  // ****************************************
  assign mix = rd_key ^ rd_fixed_challenge ^ rd_portable_challenge;

  always @(negedge ref_clk) begin
    rand_ack <= rand_req && !rand_ack;
    skd_done <= skd_start && !skd_done;
    rd_done <= rd_start && !rd_done;
    skd_key <= skd_seed ^ SECRET;
    rd_result <= {mix[RESP_W-1:0], mix};
    if (rand_req && !rand_ack) begin
      rand_data <= rnd(rand_count);
      rand_count = rand_count + 1;
    end
    if (skd_start && !skd_done) begin
      check("skd seed reuse", 1'b1, skd_seed !== prev_seed);
      prev_seed = skd_seed;
      skd_runs = skd_runs + 1;
    end
    if (rd_start && !rd_done) rd_runs = rd_runs + 1;
  end

  always @(posedge ref_clk) begin
    if (req_valid && req_ready) seen_req = req_msg;
    if (reply_valid) seen_reply = reply_msg;
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic check(input string name, input logic [127:0] exp, input logic [127:0] got);
    checked++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", name, exp, got);
      num_errors++;
    end
  endtask

  task automatic run(input logic frc, input logic bad, input logic quiet, input logic [3:0] dly,
    input logic [127:0] seed, input logic [1:0] exp_out, input int exp_skd);
    int n;
    int skd0;
    int rd0;
    skd0 = skd_runs;
    rd0 = rd_runs;
    corrupt = bad;
    mute = quiet;
    delay = dly;
    force_new_key = frc;
    start = 1'b1;
    @(negedge ref_clk);
    start = 1'b0;
    force_new_key = 1'b0;
    check("busy", 1'b1, busy);
    check("outcome cleared", OUTCOME_NONE, outcome);
    check("authenticated cleared", 1'b0, authenticated);
    n = 0;
    while (done !== 1'b1 && n < 300) begin
      @(negedge ref_clk);
      n++;
    end
    check("done", 1'b1, done);
    check("idle", 1'b0, busy);
    check("request seed", seed, seen_req.session_seed);
    check("request challenge", rnd(rand_count - 1), seen_req.fixed_challenge);
    check("key derivations", 128'(exp_skd), 128'(skd_runs - skd0));
    check("response derivations", 128'(!quiet), 128'(rd_runs - rd0));
    check("outcome", exp_out, outcome);
    check("authenticated", exp_out == OUTCOME_PASS, authenticated);
    if (!quiet) check("cipher key", seed ^ SECRET ^ seen_req.fixed_challenge ^ seen_reply.portable_challenge,
      derived_cipher_key);
    last_seed = seed;
  endtask

  task automatic t_fresh;
    run(1'b0, 1'b0, 1'b0, 4'h0, rnd(rand_count), OUTCOME_PASS, 1);
    check("portable derivations", 128'h1, 128'(derive_count));
  endtask

  task automatic t_cached_slow;
    run(1'b0, 1'b0, 1'b0, 4'h9, last_seed, OUTCOME_PASS, 0);
    check("portable derivations", 128'h1, 128'(derive_count));
  endtask

  task automatic t_force;
    run(1'b1, 1'b0, 1'b0, 4'h0, rnd(rand_count), OUTCOME_PASS, 1);
  endtask

  task automatic t_mismatch;
    run(1'b0, 1'b1, 1'b0, 4'h2, last_seed, OUTCOME_FAIL, 0);
  endtask

  task automatic t_visited;
    visited_seed = 128'h7777_0000_1111_2222_3333_4444_5555_6666;
    visited_key = visited_seed ^ SECRET;
    load_visited = 1'b1;
    @(negedge ref_clk);
    load_visited = 1'b0;
    @(negedge ref_clk);
    run(1'b1, 1'b0, 1'b0, 4'h0, visited_seed, OUTCOME_PASS, 0);
    run(1'b1, 1'b0, 1'b0, 4'h1, visited_seed, OUTCOME_PASS, 0);
  endtask

  task automatic t_timeout;
    run(1'b0, 1'b0, 1'b1, 4'h0, last_seed, OUTCOME_FAIL, 0);
  endtask

  task automatic complete_run;
    $display("Checks %0d, errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    #200000;
    num_errors++;
    $display("Error watchdog expired");
    complete_run();
  end

  initial begin
    repeat (6) @(negedge ref_clk);
    reset = 1'b0;
    t_fresh();
    t_cached_slow();
    t_force();
    t_mismatch();
    t_visited();
    t_timeout();
    complete_run();
  end
endmodule
